/* design/ubi_uart_baud_irq.sv */
// Baud divider, oversampling bit timer, majority sampler and interrupt registers
//
// Functional notes
// - Writing one to an enable-clear bit clears that interrupt enable.
// - Divider divides the function clock by value plus one; zero passes through.
// - Divider is a 16-bit field, reset zero, timing all serial operation.
// - In every mode the divider stays in path; program zero for one tick per clock.
// - Masked status is read-only, each flag ANDed with its enable.
// - Masked status bits: 3,5,6 transmit/CTS, 11..16 receive and autobaud events.
// - Oversample field 3:0 gives value plus one divided clocks per bit.
// - Oversample values 0 to 3 are illegal; value 4 gives five clocks.
// - Oversample field resets to 0xF, sixteen clocks per bit.
// - Oversampling times bits only in asynchronous modes, not synchronous.
// - In asynchronous modes the receiver takes three consecutive samples near mid-bit to decide value.
// - One disagreeing sample of a data bit sets the noise flag.
// - Writing ones to enable-set sets enables; reading returns enables.
`timescale 1ns/1ps
module ubi_uart_baud_irq (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Event pulses from the serial data path
    input wire logic evt_transmitter_quiet,
    input wire logic evt_clear_to_send_change,
    input wire logic evt_transmitter_off,
    input wire logic evt_line_break_change,
    input wire logic evt_start_detect,
    input wire logic evt_stop_bit_missing,
    input wire logic evt_parity_mismatch,
    input wire logic evt_autobaud_timeout,
    // Receive line and bit framing from the data path
    input wire logic rx_line,
    input wire logic rx_bit_restart,
    input wire logic rx_data_phase,
    // Timing outputs
    output logic baud_tick,
    output logic bit_tick,
    output logic unit_enable,
    output logic sync_mode,
    // Sampled receive bit
    output logic rx_bit_value,
    output logic rx_bit_valid,
    // Interrupt
    output logic irq
);
    logic [1:0] cfg_r;
    logic [15:0] baud_div_r;
    logic [3:0] osr_r;
    logic [16:0] irq_flags_r;
    logic [16:0] irq_flags_nxt;
    logic [16:0] irq_en_r;
    logic [16:0] irq_en_nxt;
    logic [16:0] evt_vec;
    logic [16:0] flag_clear;
    logic [16:0] masked_status;
    logic [31:0] reg_rdata_r;
    logic [31:0] rdata_nxt;
    logic [3:0] bit_count;
    logic bit_wrap;
    logic bit_restart;
    logic [3:0] mid_pos;
    logic [3:0] first_pos;
    logic [3:0] last_pos;
    logic [1:0] samp_r;
    logic samp_take;
    logic vote_now;
    logic vote_value;
    logic disagree;
    logic noise_evt;
    logic rx_bit_value_r;
    logic rx_bit_valid_r;
    logic [16:0] wmask;

    assign unit_enable = cfg_r[ubi_pkg::CFG_ENABLE_BIT];
    assign sync_mode = cfg_r[ubi_pkg::CFG_SYNC_BIT];
    assign wmask = reg_wdata[16:0] & ubi_pkg::IRQ_IMPL_MASK;

    // Configuration register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_r <= ubi_pkg::CFG_RST;
        end else if (reg_write && reg_addr == ubi_pkg::CONFIG_OFS) begin
            cfg_r <= reg_wdata[1:0];
        end
    end

    // Baud divider register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            baud_div_r <= ubi_pkg::BAUD_RST;
        end else if (reg_write && reg_addr == ubi_pkg::BAUD_DIVIDER_OFS) begin
            baud_div_r <= reg_wdata[15:0];
        end
    end

    // Oversample register; unsupported values are not taken
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            osr_r <= ubi_pkg::OSR_RST;
        end else if (reg_write && reg_addr == ubi_pkg::OVERSAMPLE_SELECT_OFS) begin
            if (reg_wdata[3:0] >= ubi_pkg::OSR_MIN) begin
                osr_r <= reg_wdata[3:0];
            end
        end
    end

    // Baud divider: no bypass in any mode, so zero means every clock
    ubi_tick_counter #(
        .W(ubi_pkg::BAUD_W)
    ) u_baud (
        .clock(clock),
        .sys_rst(sys_rst),
        .advance(unit_enable),
        .restart(!unit_enable),
        .limit(baud_div_r),
        .count(),
        .wrap(baud_tick)
    );

    // Bit timer counts divided clocks; held while synchronous
    assign bit_restart = !unit_enable || sync_mode || rx_bit_restart;

    ubi_tick_counter #(
        .W(ubi_pkg::OSR_W)
    ) u_bit (
        .clock(clock),
        .sys_rst(sys_rst),
        .advance(baud_tick),
        .restart(bit_restart),
        .limit(osr_r),
        .count(bit_count),
        .wrap(bit_wrap)
    );

    assign bit_tick = sync_mode ? baud_tick : bit_wrap;

    // Three sample positions centred on the bit
    assign mid_pos = 4'(({1'b0, osr_r} + 5'h01) >> 1);
    assign first_pos = mid_pos - 4'h1;
    assign last_pos = mid_pos + 4'h1;
    assign samp_take = baud_tick && !bit_restart && (bit_count == first_pos
        || bit_count == mid_pos);
    assign vote_now = baud_tick && !bit_restart && (bit_count == last_pos);
    assign vote_value = (samp_r[1] & samp_r[0]) | (samp_r[1] & rx_line)
        | (samp_r[0] & rx_line);
    assign disagree = !((samp_r[1] == samp_r[0]) && (samp_r[0] == rx_line));
    assign noise_evt = vote_now && disagree && rx_data_phase;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            samp_r <= 2'h0;
        end else if (samp_take) begin
            samp_r <= {samp_r[0], rx_line};
        end
    end

    // Resolved bit: majority when oversampling, single sample when synchronous
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_bit_value_r <= 1'b0;
            rx_bit_valid_r <= 1'b0;
        end else if (sync_mode && baud_tick) begin
            rx_bit_value_r <= rx_line;
            rx_bit_valid_r <= 1'b1;
        end else if (vote_now) begin
            rx_bit_value_r <= vote_value;
            rx_bit_valid_r <= 1'b1;
        end else begin
            rx_bit_valid_r <= 1'b0;
        end
    end

    assign rx_bit_value = rx_bit_value_r;
    assign rx_bit_valid = rx_bit_valid_r;

    // Event vector in status layout
    always_comb begin
        evt_vec = '0;
        evt_vec[ubi_pkg::TXQ_BIT] = evt_transmitter_quiet;
        evt_vec[ubi_pkg::CTS_BIT] = evt_clear_to_send_change;
        evt_vec[ubi_pkg::TXOFF_BIT] = evt_transmitter_off;
        evt_vec[ubi_pkg::BRK_BIT] = evt_line_break_change;
        evt_vec[ubi_pkg::START_BIT] = evt_start_detect;
        evt_vec[ubi_pkg::FRAME_BIT] = evt_stop_bit_missing;
        evt_vec[ubi_pkg::PARITY_BIT] = evt_parity_mismatch;
        evt_vec[ubi_pkg::NOISE_BIT] = noise_evt;
        evt_vec[ubi_pkg::ABAUD_BIT] = evt_autobaud_timeout;
    end

    // Sticky flags, write one to clear, a new event wins over the clear
    assign flag_clear = (reg_write && reg_addr == ubi_pkg::IRQ_FLAGS_OFS) ? wmask : '0;
    assign irq_flags_nxt = (irq_flags_r & ~flag_clear) | evt_vec;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_flags_r <= ubi_pkg::IRQ_RST;
        end else begin
            irq_flags_r <= irq_flags_nxt;
        end
    end

    // Interrupt enables through set and clear ports
    always_comb begin
        irq_en_nxt = irq_en_r;
        if (reg_write && reg_addr == ubi_pkg::IRQ_ENABLE_SET_OFS) begin
            irq_en_nxt = irq_en_r | wmask;
        end else if (reg_write && reg_addr == ubi_pkg::IRQ_ENABLE_CLEAR_OFS) begin
            irq_en_nxt = irq_en_r & ~wmask;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_en_r <= ubi_pkg::IRQ_RST;
        end else begin
            irq_en_r <= irq_en_nxt;
        end
    end

    assign masked_status = irq_flags_r & irq_en_r;
    assign irq = |masked_status;

    // Read decode, data valid in the cycle after the strobe
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (reg_addr == ubi_pkg::CONFIG_OFS) begin
            rdata_nxt = {30'h00000000, cfg_r};
        end else if (reg_addr == ubi_pkg::IRQ_FLAGS_OFS) begin
            rdata_nxt = {15'h0000, irq_flags_r};
        end else if (reg_addr == ubi_pkg::IRQ_ENABLE_SET_OFS) begin
            rdata_nxt = {15'h0000, irq_en_r};
        end else if (reg_addr == ubi_pkg::IRQ_ENABLE_CLEAR_OFS) begin
            rdata_nxt = 32'h00000000;
        end else if (reg_addr == ubi_pkg::BAUD_DIVIDER_OFS) begin
            rdata_nxt = {16'h0000, baud_div_r};
        end else if (reg_addr == ubi_pkg::MASKED_IRQ_STATUS_OFS) begin
            rdata_nxt = {15'h0000, masked_status};
        end else if (reg_addr == ubi_pkg::OVERSAMPLE_SELECT_OFS) begin
            rdata_nxt = {28'h0000000, osr_r};
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_r <= 32'h00000000;
        end else if (reg_read) begin
            reg_rdata_r <= rdata_nxt;
        end else begin
            reg_rdata_r <= 32'h00000000;
        end
    end

    assign reg_rdata = reg_rdata_r;

    // Checking helpers: cycles between baud ticks, baud ticks between bit ends
    logic [16:0] baud_gap_r;
    logic baud_gap_ok_r;
    logic [4:0] bit_gap_r;
    logic bit_gap_ok_r;
    logic div_write;
    logic osr_write;

    assign div_write = reg_write && reg_addr == ubi_pkg::BAUD_DIVIDER_OFS;
    assign osr_write = reg_write && reg_addr == ubi_pkg::OVERSAMPLE_SELECT_OFS;

    always_ff @(posedge clock) begin
        if (sys_rst || !unit_enable || div_write) begin
            baud_gap_r <= 17'h00000;
            baud_gap_ok_r <= 1'b0;
        end else if (baud_tick) begin
            baud_gap_r <= 17'h00001;
            baud_gap_ok_r <= 1'b1;
        end else begin
            baud_gap_r <= baud_gap_r + 17'h00001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || bit_restart || osr_write || div_write) begin
            bit_gap_r <= 5'h00;
            bit_gap_ok_r <= 1'b0;
        end else if (bit_wrap) begin
            bit_gap_r <= 5'h00;
            bit_gap_ok_r <= 1'b1;
        end else if (baud_tick) begin
            bit_gap_r <= bit_gap_r + 5'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    enable_clear_a: assert property (
        reg_write && reg_addr == ubi_pkg::IRQ_ENABLE_CLEAR_OFS
        |=> (irq_en_r & $past(wmask)) == 17'h00000)
        else $error("enable bit survived a clear write");

    clear_keep_a: assert property (
        reg_write && reg_addr == ubi_pkg::IRQ_ENABLE_CLEAR_OFS
        |=> ((irq_en_r ^ $past(irq_en_r)) & ~$past(wmask)) == 17'h00000)
        else $error("clear write changed an unselected enable");

    clear_read_a: assert property (
        reg_read && reg_addr == ubi_pkg::IRQ_ENABLE_CLEAR_OFS |=> reg_rdata == 32'h00000000)
        else $error("enable clear read not zero");

    enable_set_a: assert property (
        reg_write && reg_addr == ubi_pkg::IRQ_ENABLE_SET_OFS
        |=> (irq_en_r & $past(wmask)) == $past(wmask))
        else $error("enable set write not taken");

    baud_period_a: assert property (
        baud_tick && baud_gap_ok_r |-> baud_gap_r == {1'b0, baud_div_r} + 17'h00001)
        else $error("baud tick spacing wrong");

    div_reset_a: assert property (
        $fell(sys_rst) |-> baud_div_r == 16'h0000 && osr_r == 4'hF)
        else $error("divider or oversample reset value wrong");

    osr_legal_a: assert property (
        osr_write && reg_wdata[3:0] < ubi_pkg::OSR_MIN |=> $stable(osr_r))
        else $error("unsupported oversample value taken");

    bit_length_a: assert property (
        bit_wrap && bit_gap_ok_r |-> bit_gap_r == {1'b0, osr_r})
        else $error("bit length not oversample plus one");

    sync_timing_a: assert property (
        sync_mode |-> bit_tick == baud_tick && !noise_evt)
        else $error("oversampling used in synchronous mode");

    vote_value_a: assert property (
        vote_now && !sync_mode |=> rx_bit_valid && rx_bit_value ==
        (($past(samp_r[1]) + $past(samp_r[0]) + $past(rx_line)) >= 2'h2))
        else $error("majority vote wrong");

    noise_flag_a: assert property (
        vote_now && disagree && rx_data_phase |=> irq_flags_r[ubi_pkg::NOISE_BIT])
        else $error("noise flag not set");

    masked_read_a: assert property (
        reg_read && reg_addr == ubi_pkg::MASKED_IRQ_STATUS_OFS
        |=> reg_rdata == {15'h0000, $past(irq_flags_r & irq_en_r)})
        else $error("masked status read wrong");

    frame_map_a: assert property (
        evt_stop_bit_missing && irq_en_nxt[ubi_pkg::FRAME_BIT]
        |=> masked_status[ubi_pkg::FRAME_BIT])
        else $error("framing flag not at its position");

    irq_level_a: assert property (
        (evt_vec & irq_en_nxt) != 17'h00000 |=> irq)
        else $error("interrupt not raised for enabled event");

    divided_tick_c: cover property (baud_tick && baud_div_r != 16'h0000 && baud_gap_ok_r);
    noise_seen_c: cover property (noise_evt);
    irq_rise_c: cover property ($rose(irq));
    short_bit_c: cover property (bit_wrap && osr_r == ubi_pkg::OSR_MIN);
endmodule : ubi_uart_baud_irq

/* design/ubi_pkg.sv */
// Constants for the baud generator and interrupt reporting block
package ubi_pkg;
    // Register port widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [11:0] CONFIG_OFS = 12'h000;
    localparam logic [11:0] IRQ_FLAGS_OFS = 12'h008;
    localparam logic [11:0] IRQ_ENABLE_SET_OFS = 12'h00C;
    localparam logic [11:0] IRQ_ENABLE_CLEAR_OFS = 12'h010;
    localparam logic [11:0] BAUD_DIVIDER_OFS = 12'h020;
    localparam logic [11:0] MASKED_IRQ_STATUS_OFS = 12'h024;
    localparam logic [11:0] OVERSAMPLE_SELECT_OFS = 12'h028;

    // Configuration fields
    localparam int CFG_W = 2;
    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_SYNC_BIT = 1;
    localparam logic [1:0] CFG_RST = 2'h0;

    // Interrupt flag positions
    localparam int IRQ_W = 17;
    localparam int TXQ_BIT = 3;
    localparam int CTS_BIT = 5;
    localparam int TXOFF_BIT = 6;
    localparam int BRK_BIT = 11;
    localparam int START_BIT = 12;
    localparam int FRAME_BIT = 13;
    localparam int PARITY_BIT = 14;
    localparam int NOISE_BIT = 15;
    localparam int ABAUD_BIT = 16;
    localparam logic [16:0] IRQ_IMPL_MASK = 17'h1F868;
    localparam logic [16:0] IRQ_RST = 17'h00000;

    // Baud divider and oversampling
    localparam int BAUD_W = 16;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    localparam int OSR_W = 4;
    localparam logic [3:0] OSR_RST = 4'hF;
    localparam logic [3:0] OSR_MIN = 4'h4;
endpackage : ubi_pkg

/* design/ubi_tick_counter.sv */
// Wrapping counter that pulses once per limit plus one advances
`timescale 1ns/1ps
module ubi_tick_counter #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Control
    input wire logic advance,
    input wire logic restart,
    input wire logic [W-1:0] limit,
    // Status
    output logic [W-1:0] count,
    output logic wrap
);
    logic [W-1:0] count_r;

    assign count = count_r;
    assign wrap = advance && !restart && (count_r == limit);

    always_ff @(posedge clock) begin
        if (sys_rst || restart) begin
            count_r <= '0;
        end else if (advance) begin
            if (count_r == limit) begin
                count_r <= '0;
            end else begin
                count_r <= count_r + W'(1);
            end
        end
    end
endmodule : ubi_tick_counter

/* tb/ubi_serial_peer.sv */
// Model of the remote serial transmitter driving the receive line
`timescale 1ns/1ps
module ubi_serial_peer #(
    parameter int GLITCH_PHASE = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bit timing of the unit
    input wire logic unit_enable,
    input wire logic baud_tick,
    input wire logic bit_tick,
    // Traffic control from the bench
    input wire logic send_bit,
    input wire logic glitch,
    // Serial line
    output logic rx_line
);
    logic bit_r;
    logic [3:0] phase_r;

    // Tracks the position inside the current bit
    always_ff @(posedge clock) begin
        if (sys_rst || !unit_enable || bit_tick) begin
            phase_r <= 4'h0;
        end else if (baud_tick) begin
            phase_r <= phase_r + 4'h1;
        end
    end

    // New bit at each bit boundary, idle high out of reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bit_r <= 1'b1;
        end else if (bit_tick) begin
            bit_r <= send_bit;
        end
    end

    // One disagreeing sample in mid-bit when asked for
    assign rx_line = bit_r ^ (glitch && phase_r == GLITCH_PHASE[3:0]);
endmodule : ubi_serial_peer

/* tb/tb_ubi_uart_baud_irq.sv */
// Self-checking bench for the baud generator and interrupt block
`timescale 1ns/1ps
module tb_ubi_uart_baud_irq;
    localparam int EV_POS [8] = '{3, 5, 6, 11, 12, 13, 14, 16};
    logic clock, sys_rst, reg_write, reg_read, rx_line, rx_bit_restart, rx_data_phase;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed, div, oversample_select, en, e, c;
    logic [7:0] ev;
    logic baud_tick, bit_tick, unit_enable, sync_mode, rx_bit_value, rx_bit_valid, irq;
    logic send_bit, glitch;
    int fails, n_checks, p;

    ubi_uart_baud_irq ubi_uart_baud_irq_inst (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .evt_transmitter_quiet(ev[0]),
        .evt_clear_to_send_change(ev[1]), .evt_transmitter_off(ev[2]),
        .evt_line_break_change(ev[3]), .evt_start_detect(ev[4]),
        .evt_stop_bit_missing(ev[5]), .evt_parity_mismatch(ev[6]),
        .evt_autobaud_timeout(ev[7]), .rx_line(rx_line), .rx_bit_restart(rx_bit_restart),
        .rx_data_phase(rx_data_phase), .baud_tick(baud_tick), .bit_tick(bit_tick),
        .unit_enable(unit_enable), .sync_mode(sync_mode), .rx_bit_value(rx_bit_value),
        .rx_bit_valid(rx_bit_valid), .irq(irq));

    ubi_serial_peer ubi_serial_peer_inst (.clock(clock), .sys_rst(sys_rst),
        .unit_enable(unit_enable), .baud_tick(baud_tick), .bit_tick(bit_tick),
        .send_bit(send_bit), .glitch(glitch), .rx_line(rx_line));

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task rdc(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rdc

    // Cycles between two ticks of baud (which=0) or bit (which=1)
    task period(input logic which, output int n);
        n = 0;
        @(negedge clock);
        for (int i = 0; i < 2000 && (which ? bit_tick : baud_tick) !== 1'b1; i++) begin
            @(negedge clock);
        end
        do begin
            @(negedge clock);
            n++;
        end while ((which ? bit_tick : baud_tick) !== 1'b1 && n < 2000);
    endtask : period

    // Disable, reprogram, enable again
    task cfg(input logic [31:0] d, input logic [31:0] o, input logic [31:0] mode);
        wr(ubi_pkg::CONFIG_OFS, 32'h0);
        wr(ubi_pkg::BAUD_DIVIDER_OFS, d);
        wr(ubi_pkg::OVERSAMPLE_SELECT_OFS, o);
        wr(ubi_pkg::CONFIG_OFS, mode);
    endtask : cfg

    task test_done();
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        #300000;
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        seed = 32'h4665;
        fails = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        reg_addr = 12'h0;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        ev = 8'h0;
        rx_bit_restart = 1'b0;
        rx_data_phase = 1'b1;
        send_bit = 1'b1;
        glitch = 1'b0;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        rdc(ubi_pkg::BAUD_DIVIDER_OFS, 32'h0);
        rdc(ubi_pkg::OVERSAMPLE_SELECT_OFS, 32'hF);
        rdc(ubi_pkg::IRQ_ENABLE_SET_OFS, 32'h0);
        rdc(ubi_pkg::MASKED_IRQ_STATUS_OFS, 32'h0);
        rdc(12'h7FC, 32'h0);
        wr(ubi_pkg::BAUD_DIVIDER_OFS, 32'hFFFF);
        rdc(ubi_pkg::BAUD_DIVIDER_OFS, 32'hFFFF);
        // Divider and oversampling timing, corners then random
        for (int k = 0; k < 6; k++) begin
            div = (k == 0) ? 32'h0 : (k == 1) ? 32'h1 : (rnd() & 32'h7);
            oversample_select = (k == 0) ? 32'h4 : (k == 1) ? 32'hF : 32'h4 + (rnd() % 12);
            cfg(div, oversample_select, 32'h1);
            rdc(ubi_pkg::OVERSAMPLE_SELECT_OFS, oversample_select);
            period(1'b0, p);
            chk(p, div + 1);
            period(1'b1, p);
            chk(p, (oversample_select + 1) * (div + 1));
        end
        wr(ubi_pkg::OVERSAMPLE_SELECT_OFS, 32'h3);
        rdc(ubi_pkg::OVERSAMPLE_SELECT_OFS, oversample_select);
        cfg(32'h2, 32'hF, 32'h3);
        rdc(ubi_pkg::CONFIG_OFS, 32'h3);
        period(1'b1, p);
        chk(p, 32'h3);
        // Majority vote and noise flag, each bit value
        cfg(32'h0, 32'h4, 32'h1);
        // Third pass glitches outside the data phase, where no noise is flagged
        for (int b = 0; b < 2; b++) begin
            for (int g = 0; g < 3; g++) begin
                wr(ubi_pkg::IRQ_FLAGS_OFS, 32'h1F868);
                send_bit <= b[0];
                glitch <= (g != 0);
                rx_data_phase <= (g != 2);
                repeat (12) @(negedge clock);
                for (int i = 0; i < 20 && rx_bit_valid !== 1'b1; i++) @(negedge clock);
                chk({31'h0, rx_bit_value}, b);
                glitch <= 1'b0;
                rdc(ubi_pkg::IRQ_FLAGS_OFS, (g == 1) ? 32'h00008000 : 32'h0);
            end
        end
        // Each event reaches its own status bit
        wr(ubi_pkg::CONFIG_OFS, 32'h0);
        wr(ubi_pkg::IRQ_ENABLE_SET_OFS, 32'h1F868);
        for (int i = 0; i < 8; i++) begin
            wr(ubi_pkg::IRQ_FLAGS_OFS, 32'h1F868);
            ev <= 8'h1 << i;
            @(posedge clock);
            ev <= 8'h0;
            rdc(ubi_pkg::MASKED_IRQ_STATUS_OFS, 32'h1 << EV_POS[i]);
            chk({31'h0, irq}, 32'h1);
        end
        // Random enable set and clear against all events
        for (int k = 0; k < 8; k++) begin
            e = rnd() & 32'h1F868;
            c = rnd() & 32'h1F868;
            en = e & ~c & {15'h0, ubi_pkg::IRQ_IMPL_MASK};
            wr(ubi_pkg::IRQ_ENABLE_CLEAR_OFS, 32'h1F868);
            wr(ubi_pkg::IRQ_ENABLE_SET_OFS, e);
            ev <= 8'hFF;
            @(posedge clock);
            ev <= 8'h0;
            wr(ubi_pkg::IRQ_ENABLE_CLEAR_OFS, c);
            rdc(ubi_pkg::IRQ_ENABLE_SET_OFS, en);
            rdc(ubi_pkg::IRQ_ENABLE_CLEAR_OFS, 32'h0);
            rdc(ubi_pkg::MASKED_IRQ_STATUS_OFS, en & 32'h17868);
            chk({31'h0, irq}, {31'h0, |(en & 32'h17868)});
        end
        wr(ubi_pkg::IRQ_ENABLE_CLEAR_OFS, 32'h1F868);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
        test_done();
    end
endmodule : tb_ubi_uart_baud_irq
